// *** core/sgp_port.v ***
// Operation
// RULE_01: Port read returns live pin levels
// RULE_02: Reset sets all direction bits
// RULE_03: Port bits seven and six read zero
// RULE_04: Bit three input only, direction reads one
// RULE_05: Alternate function pins read zero
// RULE_06: Group pull-ups and change on 0,1,3
// RULE_07: External reset: pull-up on, no change, zero
// RULE_08: Change detection only while enable bit set
// RULE_09: External oscillator takes bits four, five
// RULE_10: Direction one floats, zero drives latch
// RULE_11: Output latch holds until rewritten
// RULE_12: Outside source holds input until sampled
// RULE_13: Each pin but three has own direction
// RULE_14: After power-on analog pins read zero
// RULE_15: Bit operations use pin levels as base
// RULE_16: Change flag sticky until software clears
// RULE_17: Compare monitored pins with last read
`timescale 1ns/1ps
`include "sgp_defs.vh"

module sgp_port (
   input wire CLK,
   input wire RSTN,
   input wire [7:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [7:0] RDATA,
   input wire [5:0] PIN_IN,
   output wire [5:0] PIN_OUT,
   output wire [5:0] PIN_OE_N,
   output wire [5:0] PULLUP_EN,
   input wire [5:0] CFG_ALT_FUNC,
   input wire CFG_EXT_RESET,
   input wire CFG_EXT_OSC,
   output wire IRQ
);

   reg [5:0] sync1_reg;
   reg [5:0] sync2_reg;
   reg [5:0] sync3_reg;
   reg [5:0] level_reg;
   reg [5:0] level_next;
   reg [5:0] latch_reg;
   reg [5:0] latch_next;
   reg [5:0] dir_reg;
   reg [5:0] dir_next;
   reg [7:0] option_reg;
   reg [7:0] option_next;
   reg [5:0] ansel_reg;
   reg [5:0] ansel_next;
   reg [6:0] intctl_reg;
   reg [6:0] intctl_next;
   reg chg_flag_reg;
   reg chg_flag_next;
   reg ien_reg;
   reg ien_next;
   reg [5:0] snap_reg;
   reg [5:0] snap_next;
   reg [7:0] rdata_next;

   wire [5:0] hidden;
   wire [5:0] taken;
   wire [5:0] view;
   wire [5:0] watched;
   wire chg_en;
   wire chg_seen;
   wire chg_clear;
   wire pullup_on;
   wire [7:0] intctl_full;
   wire rd_port;
   wire wr_bitop;
   wire wr_iclr;
   wire wr_intctl;

   // One strobe decode shared by flag and snapshot logic
   function bus_hit;
      input strobe;
      input [7:0] addr;
      input [7:0] target;
      begin
         bus_hit = strobe && (addr == target);
      end
   endfunction

   // Pins a read must hide: alternate, analog, reset and oscillator use
   function [5:0] hide_mask;
      input [5:0] alt;
      input [5:0] ana;
      input ext_rst;
      input ext_osc;
      begin
         hide_mask = alt | ana;
         if (ext_rst) begin
            hide_mask = hide_mask | `SGP_MASK_INPUT_ONLY;
         end
         if (ext_osc) begin
            hide_mask = hide_mask | `SGP_MASK_OSC;
         end
      end
   endfunction

   // What software sees when it reads the port
   function [5:0] port_view;
      input [5:0] lvl;
      input [5:0] hide;
      begin
         port_view = lvl & ~hide;
      end
   endfunction

   // Direction value as stored and read back
   function [5:0] dir_fix;
      input [5:0] d;
      begin
         dir_fix = d | `SGP_MASK_INPUT_ONLY;
      end
   endfunction

   // RULE_05: alternate pins read as zero
   assign hidden = hide_mask(CFG_ALT_FUNC, ansel_reg, CFG_EXT_RESET,
                             CFG_EXT_OSC);

   // RULE_01: reads show pin levels
   assign view = port_view(level_reg, hidden);

   // RULE_04: bit three driver never on
   // RULE_09: oscillator owns bits four and five
   assign taken = CFG_ALT_FUNC | ansel_reg |
                  (CFG_EXT_OSC ? `SGP_MASK_OSC : 6'h00) |
                  `SGP_MASK_INPUT_ONLY;

   // RULE_10: driver follows direction and latch
   assign PIN_OE_N = dir_reg | taken;
   assign PIN_OUT = latch_reg;

   // RULE_06: group pull-up on three pins
   assign pullup_on = ~option_reg[`SGP_OPT_PULLUP_OFF];

   // RULE_07: reset pin keeps its pull-up
   assign PULLUP_EN = (pullup_on ? `SGP_MASK_PULLUP : 6'h00) |
                      (CFG_EXT_RESET ? `SGP_MASK_INPUT_ONLY : 6'h00);

   // RULE_07: reset pin leaves change watch
   assign watched = CFG_EXT_RESET ?
                    (`SGP_MASK_CHANGE & ~`SGP_MASK_INPUT_ONLY) :
                    `SGP_MASK_CHANGE;

   // Full control byte; the change flag sits in bit zero
   assign intctl_full = {intctl_reg, chg_flag_reg};

   // RULE_08: change watch gated by enable bit
   assign chg_en = intctl_full[`SGP_ICR_CHG_EN];

   // RULE_17: mismatch against last read snapshot
   assign chg_seen = chg_en & (|((level_reg ^ snap_reg) & watched));

   assign rd_port = bus_hit(RD, ADDR, `SGP_ADDR_PORT);
   assign wr_bitop = bus_hit(WR, ADDR, `SGP_ADDR_BSET) ||
                     bus_hit(WR, ADDR, `SGP_ADDR_BCLR);
   assign wr_iclr = bus_hit(WR, ADDR, `SGP_ADDR_ICLR);
   assign wr_intctl = bus_hit(WR, ADDR, `SGP_ADDR_INTCTL);

   // Write one to the clear register, or zero to the flag bit
   assign chg_clear = (wr_iclr && WDATA[`SGP_IST_CHG]) ||
                      (wr_intctl && !WDATA[`SGP_ICR_CHG_FLAG]);

   // Level output: high until flag or enable drops
   assign IRQ = chg_flag_reg & ien_reg;

   // Three stages; stage one feeds only stage two
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sync1_reg <= 6'h00;
         sync2_reg <= 6'h00;
         sync3_reg <= 6'h00;
      end else begin
         sync1_reg <= PIN_IN;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // Level moves only when the last two stages agree
   always @* begin
      level_next = level_reg;
      if (sync2_reg == sync3_reg) begin
         level_next = sync3_reg;
      end
   end

   always @* begin
      latch_next = latch_reg;
      dir_next = dir_reg;
      option_next = option_reg;
      ansel_next = ansel_reg;
      intctl_next = intctl_reg;
      ien_next = ien_reg;
      snap_next = snap_reg;
      // RULE_11: latch changes only on writes
      if (WR) begin
         case (ADDR)
            `SGP_ADDR_PORT: begin
               latch_next = WDATA[5:0];
            end
            // RULE_15: set and clear start from pins
            `SGP_ADDR_BSET: begin
               latch_next = view | WDATA[5:0];
            end
            `SGP_ADDR_BCLR: begin
               latch_next = view & ~WDATA[5:0];
            end
            // RULE_13: independent direction per pin but three, forced to one
            `SGP_ADDR_DIR: begin
               dir_next = dir_fix(WDATA[5:0]);
            end
            `SGP_ADDR_OPTION: begin
               option_next = WDATA;
            end
            `SGP_ADDR_ANSEL: begin
               ansel_next = WDATA[5:0];
            end
            `SGP_ADDR_INTCTL: begin
               intctl_next = WDATA[7:1];
            end
            `SGP_ADDR_IEN: begin
               ien_next = WDATA[`SGP_IST_CHG];
            end
            default: begin
               latch_next = latch_reg;
            end
         endcase
      end
      // Snapshot also on bit ops: they read the port too
      if (rd_port || wr_bitop) begin
         snap_next = level_reg;
      end
   end

   // RULE_16: sticky flag, a new change beats the clear
   always @* begin
      chg_flag_next = chg_flag_reg;
      if (chg_clear) begin
         chg_flag_next = 1'b0;
      end
      // Persistent mismatch sets it again until a port read
      if (chg_seen) begin
         chg_flag_next = 1'b1;
      end
   end

   // Unmapped and write-only addresses read as zero
   always @* begin
      rdata_next = 8'h00;
      if (RD) begin
         case (ADDR)
            // RULE_03: upper two bits read zero
            `SGP_ADDR_PORT: begin
               rdata_next = {2'b00, view};
            end
            // RULE_04: bit three direction reads one
            `SGP_ADDR_DIR: begin
               rdata_next = {2'b00, dir_fix(dir_reg)};
            end
            `SGP_ADDR_OPTION: begin
               rdata_next = option_reg;
            end
            `SGP_ADDR_ANSEL: begin
               rdata_next = {2'b00, ansel_reg};
            end
            `SGP_ADDR_INTCTL: begin
               rdata_next = intctl_full;
            end
            `SGP_ADDR_ISTAT: begin
               rdata_next = {7'h00, chg_flag_reg};
            end
            `SGP_ADDR_IEN: begin
               rdata_next = {7'h00, ien_reg};
            end
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end
   end

   // Pin level and last-read snapshot
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         level_reg <= 6'h00;
         snap_reg <= 6'h00;
      end else begin
         level_reg <= level_next;
         snap_reg <= snap_next;
      end
   end

   // Port side: output latch and direction
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         latch_reg <= `SGP_RST_LATCH;
         // RULE_02: every pin starts as input
         dir_reg <= `SGP_RST_DIR;
      end else begin
         latch_reg <= latch_next;
         dir_reg <= dir_next;
      end
   end

   // Every reset counts as power-on, so analog select reloads too
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         option_reg <= `SGP_RST_OPTION;
         // RULE_14: analog pins read zero after power-up
         ansel_reg <= `SGP_RST_ANSEL;
      end else begin
         option_reg <= option_next;
         ansel_reg <= ansel_next;
      end
   end

   // Interrupt control, sticky flag and enable
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         intctl_reg <= `SGP_RST_INTCTL;
         chg_flag_reg <= 1'b0;
         ien_reg <= 1'b0;
      end else begin
         intctl_reg <= intctl_next;
         chg_flag_reg <= chg_flag_next;
         ien_reg <= ien_next;
      end
   end

   // Read data stands one cycle, then returns to zero
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         RDATA <= 8'h00;
      end else begin
         RDATA <= rdata_next;
      end
   end

endmodule

// *** core/sgp_defs.vh ***
`ifndef SGP_DEFS_VH
`define SGP_DEFS_VH

// Register byte addresses
`define SGP_ADDR_PORT 8'h05
`define SGP_ADDR_INTCTL 8'h0b
`define SGP_ADDR_OPTION 8'h81
`define SGP_ADDR_DIR 8'h85
`define SGP_ADDR_ISTAT 8'h90
`define SGP_ADDR_ICLR 8'h91
`define SGP_ADDR_IEN 8'h92
`define SGP_ADDR_BSET 8'h94
`define SGP_ADDR_BCLR 8'h95
`define SGP_ADDR_ANSEL 8'h9f

// Reset values
`define SGP_RST_OPTION 8'hff
`define SGP_RST_DIR 6'h3f
`define SGP_RST_ANSEL 6'h17
`define SGP_RST_LATCH 6'h00
`define SGP_RST_INTCTL 7'h00

// Field positions
`define SGP_OPT_PULLUP_OFF 7
`define SGP_ICR_CHG_EN 3
`define SGP_ICR_CHG_FLAG 0
`define SGP_IST_CHG 0
`define SGP_BIT_INPUT_ONLY 3

// Pin groups
`define SGP_MASK_CHANGE 6'h0b
`define SGP_MASK_PULLUP 6'h0b
`define SGP_MASK_INPUT_ONLY 6'h08
`define SGP_MASK_OSC 6'h30
`define SGP_PORT_WIDTH 6

`endif

// *** tb/sgp_pins.sv ***
`timescale 1ns/1ps
module sgp_pins (
   input wire clk,
   input wire [5:0] pin_out,
   input wire [5:0] pin_oe_n,
   input wire [5:0] pullup_en,
   input wire [5:0] ext_en,
   input wire [5:0] ext_val,
   output reg [5:0] pin_in = 6'h00
);
   // outside wins, held
   // Floating pins without pull-up toggle, so the level filter keeps their last level
   always @(posedge clk) begin
      pin_in <= (ext_en & ext_val) | (~ext_en & ~pin_oe_n & pin_out)
         | (~ext_en & pin_oe_n & (pullup_en | ~pin_in));
   end
endmodule

// *** tb/sgp_port_assertions.sv ***
`timescale 1ns/1ps
module sgp_port_chk (
   input wire CLK,
   input wire RSTN,
   input wire [7:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   input wire [7:0] RDATA,
   input wire [5:0] PIN_IN,
   input wire [5:0] PIN_OUT,
   input wire [5:0] PIN_OE_N,
   input wire [5:0] PULLUP_EN,
   input wire [5:0] CFG_ALT_FUNC,
   input wire CFG_EXT_RESET,
   input wire CFG_EXT_OSC,
   input wire IRQ
);
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RSTN);
   property p_in_only; PIN_OE_N[3]; endproperty
   a_in_only: assert property (p_in_only) else $error("bit3 driven");
   property p_dir_rd;
      RD && ADDR == 8'h85 |=> RDATA[7:6] == 2'b00 && RDATA[3];
   endproperty
   a_dir_rd: assert property (p_dir_rd) else $error("dir read");
   property p_port_rd;
      RD && ADDR == 8'h05 |=> RDATA[7:6] == 2'b00
         && (RDATA[5:0] & CFG_ALT_FUNC) == 6'h00;
   endproperty
   a_port_rd: assert property (p_port_rd) else $error("port read");
   property p_group;
      PULLUP_EN[0] == PULLUP_EN[1] && PULLUP_EN[5:4] == 2'b00 && !PULLUP_EN[2];
   endproperty
   a_group: assert property (p_group) else $error("pullup group");
   property p_xrst; CFG_EXT_RESET |-> PULLUP_EN[3]; endproperty
   a_xrst: assert property (p_xrst) else $error("reset pullup");
   property p_osc; CFG_EXT_OSC |-> PIN_OE_N[5:4] == 2'b11; endproperty
   a_osc: assert property (p_osc) else $error("osc pins");
   property p_latch; !WR |=> $stable(PIN_OUT); endproperty
   a_latch: assert property (p_latch) else $error("latch moved");
   property p_irq; IRQ && !WR |=> IRQ; endproperty
   a_irq: assert property (p_irq) else $error("irq dropped");
   c_irq: cover property ($rose(IRQ));
   c_osc: cover property (CFG_EXT_OSC && RD);
   c_rmw: cover property (WR && ADDR == 8'h94);
endmodule
bind sgp_port sgp_port_chk u_chk (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_IN(PIN_IN),
   .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .PULLUP_EN(PULLUP_EN),
   .CFG_ALT_FUNC(CFG_ALT_FUNC), .CFG_EXT_RESET(CFG_EXT_RESET),
   .CFG_EXT_OSC(CFG_EXT_OSC), .IRQ(IRQ));

// *** tb/tb_sgp_port.sv ***
`timescale 1ns/1ps
`define CHK(n, g, e) begin num_checks++; if ((g) !== (e)) begin \
 n_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb_sgp_port;
   reg clk = 0, rstn = 0, wr = 0, rd = 0, xrst = 0, osc = 0;
   reg [7:0] addr = 0, wdata = 0;
   reg [5:0] alt = 0, ext_en = 6'h3f, ext_val = 6'h3f;
   wire [7:0] rdata;
   wire [5:0] pin_in, pin_out, oe_n, pu;
   wire irq;
   integer n_errors = 0, num_checks = 0, cyc = 0;
   always #5 clk = ~clk;
   sgp_port u_dut (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
      .PIN_OE_N(oe_n), .PULLUP_EN(pu), .CFG_ALT_FUNC(alt),
      .CFG_EXT_RESET(xrst), .CFG_EXT_OSC(osc), .IRQ(irq));
   sgp_pins u_pins (.clk(clk), .pin_out(pin_out), .pin_oe_n(oe_n),
      .pullup_en(pu), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
   task w(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         wr <= 1;
         addr <= a;
         wdata <= d;
         @(posedge clk);
         wr <= 0;
         #1;
      end
   endtask
   task r(input [7:0] a, input [7:0] m, input [7:0] e);
      begin
         @(posedge clk);
         rd <= 1;
         addr <= a;
         @(posedge clk);
         rd <= 0;
         #1;
         `CHK("rdata", rdata & m, e)
      end
   endtask
   // Pins must settle through the input synchroniser
   task p(input [5:0] en, input [5:0] v);
      begin
         @(posedge clk);
         ext_en <= en;
         ext_val <= v;
         repeat (8) @(posedge clk);
         #1;
      end
   endtask
   task results;
      begin
         $display("checks %0d errors %0d", num_checks, n_errors);
         if (n_errors == 0 && num_checks > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 2000) begin
         n_errors = n_errors + 1;
         results;
      end
   end
   task test_reset;
      begin
         r(8'h85, 8'hff, 8'h3f);
         r(8'h81, 8'hff, 8'hff);
         r(8'h05, 8'hff, 8'h28);
         r(8'h40, 8'hff, 8'h00);
         `CHK("pullup", pu, 6'h00)
         $display("reset test done");
      end
   endtask
   task test_dir;
      begin
         w(8'h9f, 8'h00);
         w(8'h85, 8'h00);
         r(8'h85, 8'hff, 8'h08);
         `CHK("oe_n", oe_n, 6'h08)
         w(8'h05, 8'h15);
         p(6'h08, 6'h08);
         r(8'h05, 8'hff, 8'h1d);
         p(6'h09, 6'h08);
         r(8'h05, 8'h01, 8'h00);
         $display("direction test done");
      end
   endtask
   task test_change;
      begin
         w(8'h0b, 8'h08);
         w(8'h92, 8'h01);
         r(8'h05, 8'h02, 8'h00);
         p(6'h0b, 6'h0a);
         `CHK("irq", irq, 1'b1)
         r(8'h90, 8'h01, 8'h01);
         r(8'h05, 8'h02, 8'h02);
         w(8'h91, 8'h01);
         `CHK("irq", irq, 1'b0)
         w(8'h0b, 8'h00);
         p(6'h0b, 6'h09);
         r(8'h90, 8'h01, 8'h00);
         w(8'h92, 8'h00);
         w(8'h0b, 8'h08);
         r(8'h90, 8'h01, 8'h01);
         `CHK("irq", irq, 1'b0)
         $display("change test done");
      end
   endtask
   task test_rmw;
      begin
         p(6'h28, 6'h28);
         w(8'h94, 8'h01);
         `CHK("latch", pin_out & 6'h37, 6'h35)
         w(8'h95, 8'h20);
         `CHK("latch", pin_out & 6'h37, 6'h15)
         $display("rmw test done");
      end
   endtask
   task test_config;
      begin
         w(8'h85, 8'h3f);
         w(8'h81, 8'h7f);
         @(posedge clk);
         alt <= 6'h04;
         xrst <= 1;
         osc <= 1;
         p(6'h3f, 6'h3f);
         r(8'h05, 8'h0f, 8'h03);
         `CHK("pullup", pu, 6'h0b)
         w(8'h85, 8'h00);
         `CHK("oe_n", oe_n, 6'h3c)
         $display("config test done");
      end
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1;
      repeat (5) @(posedge clk);
      test_reset;
      test_dir;
      test_change;
      test_rmw;
      test_config;
      results;
   end
endmodule
